// ===== src/ssd_segment_delivery.sv
// Socket segment delivery: segmenting sender, acknowledged resend, receive delivery
`timescale 1ns/10ps
// =============================================================
// Functional notes
// - TCP payload leaves in consecutive segments of at most 1,024 bytes
// - UDP payload leaves in pieces of at most 1,472 bytes
// - A TCP receive request delivers at most one arrived unit
// - UDP pieces are joined into one datagram before delivery
// - Short UDP request gets its length; rest of datagram is dropped
// - Short TCP request leaves remainder pending for later requests
// - TCP sends next data after ack, resends same data on timeout
// - UDP data is never checked nor resent by the block
// - Port number zero is refused for every socket
// - Only the first opened TCP socket talks until it closes
// - Several UDP sockets may exchange data at once
// - Passive open waits as server, active open requests as client
// - TCP send is only accepted over an established connection
// - Per-socket receiving flag set on request, cleared on completion
module ssd_segment_delivery #(
    parameter int unsigned ACK_TMO_CYC = ssd_pkg::ACK_TMO_CYC,
    parameter int unsigned TX_AW       = 11,
    parameter int unsigned RX_AW       = 12
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Open and close requests
    input  wire logic        openReq,
    input  wire logic        openIsTcp,
    input  wire logic        openActive,
    input  wire logic [3:0]  openSock,
    input  wire logic [15:0] openPort,
    input  wire logic        closeReq,
    input  wire logic        closeIsTcp,
    input  wire logic [3:0]  closeSock,
    output logic             openRefused_ff,
    output logic             connReq_ff,
    output logic             tcpConnected_ff,
    output logic [7:0]       udpOpen_ff,
    // Peer connection events
    input  wire logic        peerConnReq,
    input  wire logic        peerConnAck,
    // Send request and payload
    input  wire logic        sendReq,
    input  wire logic        sendIsTcp,
    input  wire logic [3:0]  sendSock,
    input  wire logic [15:0] sendLen,
    input  wire logic [7:0]  payData,
    input  wire logic        payValid,
    output logic             payReady,
    output logic             sendBusy_ff,
    output logic             sendRefused_ff,
    // Segment link out
    output logic [7:0]       txData,
    output logic             txValid_ff,
    output logic             txLast_ff,
    input  wire logic        ackIn,
    // Receive link in
    input  wire logic [7:0]  rxData,
    input  wire logic        rxValid,
    input  wire logic        rxIsTcp,
    input  wire logic [3:0]  rxSock,
    input  wire logic        rxPieceEnd,
    input  wire logic        rxDgramEnd,
    output logic             rxReady_ff,
    // Receive request and delivery
    input  wire logic        rcvReq,
    input  wire logic        rcvIsTcp,
    input  wire logic [3:0]  rcvSock,
    input  wire logic [15:0] rcvLen,
    output logic [7:0]       rcvData,
    output logic             rcvValid_ff,
    output logic             rcvDone_ff,
    output logic [15:0]      rcvCount_ff,
    output logic             rcvRefused_ff,
    output logic [15:0]      rcvFlags_ff
);
    if (TX_AW < ssd_pkg::TX_AW_MIN || RX_AW < TX_AW || ACK_TMO_CYC < 2) begin : g_chk
        $error("ssd_segment_delivery: buffer or timeout parameters too small");
    end

    // =========================================================
    // Open, close and connection
    logic       tcpOwned_ff;
    logic       tcpActive_ff;
    logic [3:0] tcpOwner_ff;

    wire       openSockOk = openSock != ssd_pkg::SOCK_NONE && openSock <= ssd_pkg::SOCK_COUNT;
    wire       openPortOk = openPort != ssd_pkg::PORT_NONE;
    wire       openTake   = openReq && openSockOk && openPortOk
                            && (!openIsTcp || !tcpOwned_ff);
    wire [2:0] openIdx    = openSock[2:0] - 3'h1;
    wire [2:0] closeIdx   = closeSock[2:0] - 3'h1;
    wire       tcpClose   = closeReq && closeIsTcp && tcpOwned_ff && closeSock == tcpOwner_ff;
    wire       connUp     = tcpOwned_ff && !tcpConnected_ff
                            && (tcpActive_ff ? peerConnAck : peerConnReq);
    wire [7:0] udpSet     = (openTake && !openIsTcp) ? (8'h01 << openIdx) : 8'h00;
    wire [7:0] udpClr     = (closeReq && !closeIsTcp) ? (8'h01 << closeIdx) : 8'h00;

    // One TCP owner at a time; active open asks the peer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tcpOwned_ff     <= 1'b0;
            tcpActive_ff    <= 1'b0;
            tcpOwner_ff     <= 4'h0;
            tcpConnected_ff <= 1'b0;
            connReq_ff      <= 1'b0;
            openRefused_ff  <= 1'b0;
        end else begin
            openRefused_ff <= openReq && !openTake;
            connReq_ff     <= openTake && openIsTcp && openActive;
            if (openTake && openIsTcp) begin
                tcpOwned_ff  <= 1'b1;
                tcpOwner_ff  <= openSock;
                tcpActive_ff <= openActive;
            end else if (tcpClose) begin
                tcpOwned_ff <= 1'b0;
            end
            tcpConnected_ff <= !tcpClose && (tcpConnected_ff || connUp);
        end
    end

    // UDP sockets open independently; open wins over close
    for (genvar s = 0; s < 8; s++) begin : g_udp
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                udpOpen_ff[s] <= 1'b0;
            end else if (udpSet[s]) begin
                udpOpen_ff[s] <= 1'b1;
            end else if (udpClr[s]) begin
                udpOpen_ff[s] <= 1'b0;
            end
        end
    end

    // =========================================================
    // Transmit segmenting
    ssd_pkg::ssd_tx_e txState_ff;
    ssd_pkg::ssd_tx_e nxt_txState;
    logic [15:0] txRemain_ff;
    logic        txTcp_ff;
    logic [15:0] fillCnt_ff;
    logic [15:0] sendCnt_ff;
    logic [31:0] tmoCnt_ff;
    logic [7:0]  fifoData;
    logic        fifoValid;

    wire [2:0]  sendIdx    = sendSock[2:0] - 3'h1;
    wire        sendSockOk = sendSock != ssd_pkg::SOCK_NONE && sendSock <= ssd_pkg::SOCK_COUNT;
    wire        sendRight  = sendIsTcp ? (tcpConnected_ff && sendSock == tcpOwner_ff)
                                       : udpOpen_ff[sendIdx];
    wire        sendTake   = sendReq && txState_ff == ssd_pkg::TX_IDLE && sendSockOk
                             && sendLen != 16'h0 && sendRight;
    wire [15:0] segCap     = txTcp_ff ? ssd_pkg::TCP_SEG_MAX : ssd_pkg::UDP_SEG_MAX;
    wire [15:0] segLen     = (txRemain_ff > segCap) ? segCap : txRemain_ff;
    wire        fillPop    = txState_ff == ssd_pkg::TX_FILL && fifoValid;
    wire        fillLast   = fillPop && fillCnt_ff == segLen - 16'h1;
    wire        sendRd     = txState_ff == ssd_pkg::TX_SEND;
    wire        sendEnd    = sendRd && sendCnt_ff == segLen - 16'h1;
    wire        txWaiting  = txState_ff == ssd_pkg::TX_WAIT;
    wire        tmoHit     = txWaiting && tmoCnt_ff == 32'(ACK_TMO_CYC - 1);
    wire        segDone    = (sendEnd && !txTcp_ff) || (txWaiting && ackIn);
    wire        lastSeg    = txRemain_ff == segLen;

    // Next transmit state
    always_comb begin
        nxt_txState = txState_ff;
        case (txState_ff)
            ssd_pkg::TX_IDLE: if (sendTake) nxt_txState = ssd_pkg::TX_FILL;
            ssd_pkg::TX_FILL: if (fillLast) nxt_txState = ssd_pkg::TX_SEND;
            ssd_pkg::TX_SEND: begin
                if (sendEnd && txTcp_ff) begin
                    nxt_txState = ssd_pkg::TX_WAIT;
                end else if (sendEnd) begin
                    nxt_txState = lastSeg ? ssd_pkg::TX_IDLE : ssd_pkg::TX_FILL;
                end
            end
            ssd_pkg::TX_WAIT: begin
                if (ackIn) begin
                    nxt_txState = lastSeg ? ssd_pkg::TX_IDLE : ssd_pkg::TX_FILL;
                end else if (!tcpConnected_ff) begin
                    nxt_txState = ssd_pkg::TX_IDLE;
                end else if (tmoHit) begin
                    nxt_txState = ssd_pkg::TX_SEND;
                end
            end
            default: nxt_txState = ssd_pkg::TX_IDLE;
        endcase
    end

    // Segment counters restart whenever their state is left
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txState_ff     <= ssd_pkg::TX_IDLE;
            txRemain_ff    <= 16'h0;
            txTcp_ff       <= 1'b0;
            fillCnt_ff     <= 16'h0;
            sendCnt_ff     <= 16'h0;
            tmoCnt_ff      <= 32'h0;
            txValid_ff     <= 1'b0;
            txLast_ff      <= 1'b0;
            sendBusy_ff    <= 1'b0;
            sendRefused_ff <= 1'b0;
        end else begin
            txState_ff     <= nxt_txState;
            txRemain_ff    <= sendTake ? sendLen : (segDone ? txRemain_ff - segLen : txRemain_ff);
            txTcp_ff       <= sendTake ? sendIsTcp : txTcp_ff;
            fillCnt_ff     <= fillLast ? 16'h0 : fillCnt_ff + 16'(fillPop);
            sendCnt_ff     <= sendEnd ? 16'h0 : sendCnt_ff + 16'(sendRd);
            tmoCnt_ff      <= txWaiting ? tmoCnt_ff + 32'h1 : 32'h0;
            txValid_ff     <= sendRd;
            txLast_ff      <= sendEnd;
            sendBusy_ff    <= nxt_txState != ssd_pkg::TX_IDLE;
            sendRefused_ff <= sendReq && !sendTake;
        end
    end

    // Payload FIFO only drains while a segment is being filled
    ssd_fifo #(.WIDTH(8), .DEPTH(ssd_pkg::FIFO_DEPTH)) u_payFifo (
        .clk        (clk),
        .rst_n      (rst_n),
        .inData     (payData),
        .inValid    (payValid),
        .inReady_ff (payReady),
        .outData    (fifoData),
        .outValid   (fifoValid),
        .outReady   (txState_ff == ssd_pkg::TX_FILL)
    );

    // Segment copy kept until acknowledged, so a resend replays it
    ssd_ram #(.DW(8), .AW(TX_AW)) u_txRam (
        .clk    (clk),
        .wrEn   (fillPop),
        .wrAddr (fillCnt_ff[TX_AW-1:0]),
        .wrData (fifoData),
        .rdAddr (sendCnt_ff[TX_AW-1:0]),
        .rdData (txData)
    );

    // =========================================================
    // Receive buffering and delivery
    ssd_pkg::ssd_rd_e rdState_ff;
    ssd_pkg::ssd_rd_e nxt_rdState;
    logic [15:0] wrCnt_ff;
    logic        pendFull_ff;
    logic [15:0] pendLen_ff;
    logic        pendTcp_ff;
    logic [3:0]  pendSock_ff;
    logic [15:0] rdPtr_ff;
    logic        reqTcp_ff;
    logic [3:0]  reqSock_ff;
    logic [15:0] reqLen_ff;
    logic [15:0] dlvLen_ff;
    logic [15:0] outCnt_ff;

    wire        rxWr      = rxValid && rxReady_ff;
    wire        rxEnd     = rxWr && (rxIsTcp ? rxPieceEnd : rxDgramEnd);
    wire        rcvSockOk = rcvSock != ssd_pkg::SOCK_NONE && rcvSock <= ssd_pkg::SOCK_COUNT;
    wire        rcvTake   = rcvReq && rdState_ff == ssd_pkg::RD_IDLE && rcvSockOk
                            && rcvLen != 16'h0;
    wire        rdMatch   = pendFull_ff && pendTcp_ff == reqTcp_ff && pendSock_ff == reqSock_ff;
    wire [15:0] avail     = pendLen_ff - rdPtr_ff;
    wire [15:0] dlvLen    = (reqLen_ff < avail) ? reqLen_ff : avail;
    wire        outRd     = rdState_ff == ssd_pkg::RD_OUT;
    wire        outEnd    = outRd && outCnt_ff == dlvLen_ff - 16'h1;
    wire        pendClr   = outEnd && (!pendTcp_ff || rdPtr_ff + 16'h1 == pendLen_ff);
    wire [15:0] flagSet   = rcvTake ? (16'h0001 << {rcvIsTcp, rcvSock[2:0] - 3'h1}) : 16'h0;
    wire [15:0] flagClr   = outEnd ? (16'h0001 << {reqTcp_ff, reqSock_ff[2:0] - 3'h1}) : 16'h0;

    // Next delivery state
    always_comb begin
        nxt_rdState = rdState_ff;
        case (rdState_ff)
            ssd_pkg::RD_IDLE: if (rcvTake) nxt_rdState = ssd_pkg::RD_WAIT;
            ssd_pkg::RD_WAIT: if (rdMatch) nxt_rdState = ssd_pkg::RD_OUT;
            ssd_pkg::RD_OUT:  if (outEnd) nxt_rdState = ssd_pkg::RD_IDLE;
            default:          nxt_rdState = ssd_pkg::RD_IDLE;
        endcase
    end

    // One unit or datagram held at a time; link stalls while it is held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdState_ff    <= ssd_pkg::RD_IDLE;
            wrCnt_ff      <= 16'h0;
            pendFull_ff   <= 1'b0;
            pendLen_ff    <= 16'h0;
            pendTcp_ff    <= 1'b0;
            pendSock_ff   <= 4'h0;
            rdPtr_ff      <= 16'h0;
            rxReady_ff    <= 1'b1;
        end else begin
            rdState_ff  <= nxt_rdState;
            wrCnt_ff    <= pendClr ? 16'h0 : wrCnt_ff + 16'(rxWr);
            pendFull_ff <= rxEnd || (pendFull_ff && !pendClr);
            pendLen_ff  <= rxEnd ? wrCnt_ff + 16'h1 : pendLen_ff;
            pendTcp_ff  <= rxEnd ? rxIsTcp : pendTcp_ff;
            pendSock_ff <= rxEnd ? rxSock : pendSock_ff;
            rdPtr_ff    <= pendClr ? 16'h0 : rdPtr_ff + 16'(outRd);
            rxReady_ff  <= pendClr || (!pendFull_ff && !rxEnd);
        end
    end

    // Request capture, delivery count and result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reqTcp_ff     <= 1'b0;
            reqSock_ff    <= 4'h0;
            reqLen_ff     <= 16'h0;
            dlvLen_ff     <= 16'h0;
            outCnt_ff     <= 16'h0;
            rcvValid_ff   <= 1'b0;
            rcvDone_ff    <= 1'b0;
            rcvCount_ff   <= 16'h0;
            rcvRefused_ff <= 1'b0;
        end else begin
            reqTcp_ff     <= rcvTake ? rcvIsTcp : reqTcp_ff;
            reqSock_ff    <= rcvTake ? rcvSock : reqSock_ff;
            reqLen_ff     <= rcvTake ? rcvLen : reqLen_ff;
            dlvLen_ff     <= (rdState_ff == ssd_pkg::RD_WAIT) ? dlvLen : dlvLen_ff;
            outCnt_ff     <= outEnd ? 16'h0 : outCnt_ff + 16'(outRd);
            rcvValid_ff   <= outRd;
            rcvDone_ff    <= outEnd;
            rcvCount_ff   <= outEnd ? dlvLen_ff : rcvCount_ff;
            rcvRefused_ff <= rcvReq && !rcvTake;
        end
    end

    // Receiving flags; a set in the same cycle wins over the clear
    for (genvar f = 0; f < 16; f++) begin : g_flag
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                rcvFlags_ff[f] <= 1'b0;
            end else if (flagSet[f]) begin
                rcvFlags_ff[f] <= 1'b1;
            end else if (flagClr[f]) begin
                rcvFlags_ff[f] <= 1'b0;
            end
        end
    end

    // Reassembly buffer; RX_AW bounds the largest datagram held
    ssd_ram #(.DW(8), .AW(RX_AW)) u_rxRam (
        .clk    (clk),
        .wrEn   (rxWr),
        .wrAddr (wrCnt_ff[RX_AW-1:0]),
        .wrData (rxData),
        .rdAddr (rdPtr_ff[RX_AW-1:0]),
        .rdData (rcvData)
    );

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_TCP_SEG: assert property (fillPop && txTcp_ff |-> fillCnt_ff < 16'h0400)
        else $error("TCP segment exceeds 1024 bytes");
    AST_UDP_SEG: assert property (fillPop && !txTcp_ff |-> fillCnt_ff < 16'h05c0)
        else $error("UDP piece exceeds 1472 bytes");
    AST_RESEND: assert property (tmoHit && !ackIn && tcpConnected_ff
        |=> txState_ff == ssd_pkg::TX_SEND ##1 sendCnt_ff == 16'h1)
        else $error("Timeout did not resend the segment");
    AST_ACK_ADV: assert property (txWaiting && ackIn |=> txState_ff != ssd_pkg::TX_SEND)
        else $error("Ack did not advance transmit");
    AST_UDP_NOWAIT: assert property (sendEnd && !txTcp_ff |=> !txWaiting)
        else $error("UDP waits for acknowledgement");
    AST_PORT0: assert property (openReq && openPort == 16'h0 && !closeReq |=> openRefused_ff
        && $stable(udpOpen_ff))
        else $error("Port zero accepted");
    AST_ONE_TCP: assert property (openReq && openIsTcp && tcpOwned_ff
        |=> openRefused_ff && tcpOwner_ff == $past(tcpOwner_ff))
        else $error("Second TCP socket opened");
    AST_CONN_FIRST: assert property (sendRd && txTcp_ff |-> tcpConnected_ff)
        else $error("TCP data without connection");
    AST_FLAG: assert property (rcvTake |=> rcvFlags_ff != 16'h0 ##0
        rcvFlags_ff[{reqTcp_ff, reqSock_ff[2:0] - 3'h1}])
        else $error("Receiving flag not set");
    AST_UDP_DROP: assert property (outEnd && !pendTcp_ff |=> !pendFull_ff ##0 rxReady_ff)
        else $error("UDP remainder not discarded");
    AST_TCP_KEEP: assert property (outEnd && pendTcp_ff && rdPtr_ff + 16'h1 != pendLen_ff
        |=> pendFull_ff && rdPtr_ff == $past(rdPtr_ff) + 16'h1)
        else $error("TCP remainder lost");
    AST_COUNT: assert property (rcvDone_ff |-> rcvCount_ff <= reqLen_ff && rcvValid_ff)
        else $error("Delivered count wrong");

    COV_RESEND: cover property (tmoHit ##1 txState_ff == ssd_pkg::TX_SEND);
    COV_UDP_TRUNC: cover property (outEnd && !pendTcp_ff && rdPtr_ff + 16'h1 != pendLen_ff);
    COV_TCP_PART: cover property (outEnd && pendTcp_ff && rdPtr_ff + 16'h1 != pendLen_ff);
    COV_ACTIVE: cover property (connReq_ff ##[1:20] tcpConnected_ff);
endmodule : ssd_segment_delivery

// ===== src/ssd_pkg.sv
// Shared constants and state types of the socket segment delivery block
package ssd_pkg;
    // =========================================================
    // Segmenting and sockets
    localparam logic [15:0] TCP_SEG_MAX = 16'h0400; // 1,024 bytes
    localparam logic [15:0] UDP_SEG_MAX = 16'h05c0; // 1,472 bytes
    localparam logic [3:0]  SOCK_COUNT  = 4'h8;
    localparam logic [3:0]  SOCK_NONE   = 4'h0;
    localparam logic [15:0] PORT_NONE   = 16'h0000;
    localparam int unsigned FIFO_DEPTH  = 4;
    localparam int unsigned TX_AW_MIN   = 11;

    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned ACK_TMO_US    = 1000;
    localparam int unsigned ACK_TMO_CYC   = (ACK_TMO_US * 1000) / CLK_PERIOD_NS;

    // =========================================================
    // State types
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_FILL = 2'b01,
        TX_SEND = 2'b10,
        TX_WAIT = 2'b11
    } ssd_tx_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_OUT  = 2'b10
    } ssd_rd_e;
endpackage : ssd_pkg

// ===== src/ssd_fifo.sv
// Small payload FIFO with valid and ready on both sides
`timescale 1ns/10ps
module ssd_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = ssd_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady_ff,
    // Drain side
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // =========================================================
    // Storage and pointers
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("ssd_fifo: DEPTH must be a power of two of at least 2");
    end

    // Handshakes
    wire          push      = inValid && inReady_ff;
    wire          pop       = outValid && outReady;
    wire [AW:0]   nxt_count = count_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    assign outValid = count_ff != '0;
    assign outData  = store[rdPtr_ff];

    // Ready registered so the source sees honest back-pressure
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_ff   <= '0;
            rdPtr_ff   <= '0;
            count_ff   <= '0;
            inReady_ff <= 1'b0;
        end else begin
            wrPtr_ff   <= wrPtr_ff + AW'(push);
            rdPtr_ff   <= rdPtr_ff + AW'(pop);
            count_ff   <= nxt_count;
            inReady_ff <= nxt_count < (AW + 1)'(DEPTH);
        end
    end

    // Data words need no reset
    always_ff @(posedge clk) begin
        if (push) begin
            store[wrPtr_ff] <= inData;
        end
    end
endmodule : ssd_fifo

// ===== src/ssd_ram.sv
// Byte buffer memory with registered read data
`timescale 1ns/10ps
module ssd_ram #(
    parameter int unsigned DW = 8,
    parameter int unsigned AW = 11
) (
    // Clock
    input  wire logic          clk,
    // Write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    // Read port
    input  wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0]      rdData
);
    // =========================================================
    // Array
    logic [DW-1:0] mem [1 << AW];

    // Read data always one cycle after the address
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : ssd_ram

// ===== test/ssd_peer_model.sv
// Remote node model: accepts active opens and acknowledges segments
`timescale 1ns/10ps
module ssd_peer_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Link events
    input  wire logic connReq,
    input  wire logic txLast,
    input  wire logic dropFirst,
    output logic      peerConnAck,
    output logic      ackIn
);
    logic [1:0] ackDly_ff;
    logic       dropped_ff;
    // Losing the first ack forces the sender to time out and resend
    always @(posedge clk) begin
        peerConnAck <= rst_n & connReq;
        ackIn       <= rst_n && ackDly_ff == 2'h1;
        if (!rst_n || txLast && dropFirst && !dropped_ff) begin
            dropped_ff <= rst_n;
            ackDly_ff  <= 2'h0;
        end else if (txLast) begin
            ackDly_ff <= 2'h3;
        end else if (ackDly_ff != 2'h0) begin
            ackDly_ff <= ackDly_ff - 2'h1;
        end
    end
endmodule : ssd_peer_model

// ===== test/tb_top.sv
// Self-checking bench for the socket segment delivery block
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rst_n = 0, dropFirst = 0, openReq = 0, openIsTcp = 0, openActive = 0;
    logic closeReq = 0, closeIsTcp = 1, peerConnReq = 0, sendReq = 0, sendIsTcp = 0;
    logic payValid = 1, rxValid = 0, rxIsTcp = 0, rxPieceEnd = 0, rxDgramEnd = 0;
    logic rcvReq = 0, rcvIsTcp = 0, openRefused_ff, connReq_ff, tcpConnected_ff, payReady;
    logic sendBusy_ff, sendRefused_ff, txValid_ff, txLast_ff, rxReady_ff, rcvValid_ff;
    logic rcvDone_ff, rcvRefused_ff, peerConnAck, ackIn;
    logic [3:0]  openSock = 0, closeSock = 3, sendSock = 0, rxSock = 0, rcvSock = 0;
    logic [7:0]  payData = 8'h05, rxData = 0, udpOpen_ff, txData, rcvData;
    logic [15:0] openPort = 0, sendLen = 0, rcvLen = 0, rcvCount_ff, rcvFlags_ff, segLen = 0;
    logic [23:0] segQ[$];
    int          nErrors = 0, totalChecks = 0;
    ssd_segment_delivery #(.ACK_TMO_CYC(20)) DUT (.*);
    ssd_peer_model PEER (.clk, .rst_n, .connReq(connReq_ff), .txLast(txLast_ff), .dropFirst,
        .peerConnAck, .ackIn);
    // Segment monitor: last byte and length of each segment
    always @(posedge clk) begin
        if (txValid_ff) segLen = segLen + 16'h1;
        if (txValid_ff && txLast_ff) begin
            segQ.push_back({txData, segLen});
            segLen = 0;
        end
        if (payValid && payReady) payData <= payData + 8'h01;
    end
    // Clock
    initial forever #20 clk = ~clk;
    task automatic tick(int n = 1);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Bounded wait; a hang counts as a mismatch
    task automatic waitOn(ref logic sig, input logic lvl);
        for (int i = 0; i < 9000 && sig !== lvl; i++) tick();
        if (sig !== lvl) begin
            nErrors++;
            final_report();
        end
    endtask : waitOn
    task automatic doOpen(logic tcp, logic act, logic [3:0] s, logic [15:0] p);
        tick();
        {openReq, openIsTcp, openActive, openSock, openPort} = {1'b1, tcp, act, s, p};
        tick();
        openReq = 0;
    endtask : doOpen
    task automatic doSend(logic tcp, logic [3:0] s, logic [15:0] n);
        segQ.delete();
        {sendReq, sendIsTcp, sendSock, sendLen} = {1'b1, tcp, s, n};
        tick();
        sendReq = 0;
        waitOn(sendBusy_ff, 1'b0);
        tick();
        chk("payFull", 0, payReady);
    endtask : doSend
    task automatic doBadSend(logic tcp, logic [3:0] s);
        {sendReq, sendIsTcp, sendSock, sendLen} = {1'b1, tcp, s, 16'd8};
        tick();
        sendReq = 0;
        chk("sendRefused", 1, sendRefused_ff);
        tick();
    endtask : doBadSend
    task automatic doRx(logic tcp, logic [3:0] s, int n);
        for (int i = 0; i < n; i++) begin
            waitOn(rxReady_ff, 1'b1);
            {rxValid, rxIsTcp, rxSock, rxData} = {1'b1, tcp, s, 8'(i)};
            {rxPieceEnd, rxDgramEnd} = {tcp ? i == n - 1 : i == 1, !tcp && i == n - 1};
            tick();
        end
        rxValid = 0;
    endtask : doRx
    task automatic doRcv(logic tcp, logic [3:0] s, logic [15:0] n, logic [15:0] exp,
                         logic [7:0] last);
        logic [3:0] idx;
        idx = {tcp, 3'(s - 4'h1)};
        {rcvReq, rcvIsTcp, rcvSock, rcvLen} = {1'b1, tcp, s, n};
        tick();
        chk("rcvFlag", 1, rcvFlags_ff[idx]);
        tick();
        rcvReq = 0;
        chk("rcvRefused", 1, rcvRefused_ff);
        waitOn(rcvDone_ff, 1'b1);
        chk("rcvCount", 24'(exp), 24'(rcvCount_ff));
        chk("rcvLast", {2'h2, last}, {rcvValid_ff, rcvFlags_ff[idx], rcvData});
    endtask : doRcv
    // Main sequence
    initial begin
        tick(16);
        rst_n = 1;
        tick();
        doOpen(1, 1, 3, 0);
        chk("portZero", 1, openRefused_ff);
        doOpen(1, 1, 3, 16'h1000);
        chk("connReq", 1, connReq_ff);
        tick(3);
        chk("connected", 1, tcpConnected_ff);
        doOpen(1, 0, 5, 16'h1001);
        chk("secondTcp", 1, openRefused_ff);
        doOpen(0, 0, 2, 16'h1002);
        doOpen(0, 0, 4, 16'h1003);
        chk("udpOpen", 8'h0a, udpOpen_ff);
        dropFirst = 1;
        doSend(1, 3, 16'd1100);
        chk("tcpSegs", 3, segQ.size());
        chk("seg0", {8'h04, 16'd1024}, segQ[0]);
        chk("resent", {8'h04, 16'd1024}, segQ[1]);
        chk("seg2", {8'h50, 16'd76}, segQ[2]);
        doSend(0, 2, 16'd1500);
        chk("udpSegs", 2, segQ.size());
        chk("useg0", {8'h10, 16'd1472}, segQ[0]);
        chk("useg1", {8'h2c, 16'd28}, segQ[1]);
        doBadSend(1, 5);
        doBadSend(0, 1);
        doRx(1, 3, 4);
        doRcv(1, 3, 16'd3, 16'd3, 8'h02);
        doRcv(1, 3, 16'd9, 16'd1, 8'h03);
        doRx(0, 2, 5);
        doRcv(0, 2, 16'd2, 16'd2, 8'h01);
        doRx(0, 2, 3);
        doRcv(0, 2, 16'd9, 16'd3, 8'h02);
        closeReq = 1;
        tick();
        closeReq = 0;
        tick();
        chk("closed", 0, tcpConnected_ff);
        doOpen(1, 0, 5, 16'h1004);
        chk("reopen", 0, openRefused_ff);
        peerConnReq = 1;
        tick();
        peerConnReq = 0;
        tick();
        chk("passive", 1, tcpConnected_ff);
        final_report();
    end
endmodule : tb_top
